// file: verilog/atsg_pkg.sv
// shared constants and types of the test-signal playback block
package atsg_pkg;

  // system clock rate; one sample per clock is the playback ceiling
  localparam logic [31:0] CLK_HZ          = 32'h0262_5A00;
  // fastest sample clock the playback path supports
  localparam logic [31:0] MAX_RATE_HZ     = CLK_HZ;
  // fixed sample clock of the constant test signal (10 kHz)
  localparam logic [31:0] CONST_RATE_HZ   = 32'h0000_2710;
  // sample clock after defaults are restored (1 MHz)
  localparam logic [31:0] DEFAULT_RATE_HZ = 32'h000F_4240;

  // sample full scale, +1 and -1
  localparam logic signed [15:0] POS_FULL = 16'sh7FFF;
  localparam logic signed [15:0] NEG_FULL = 16'sh8001;
  // one whole turn of the 16-bit phase word
  localparam logic [16:0] PHASE_TURN      = 17'h1_0000;
  // number of decimal digits in a constant setting
  localparam int unsigned BCD_DIGITS      = 5;

  // test signal forms selectable by software
  typedef enum logic [1:0] {
    ATSG_SINE,
    ATSG_RECT,
    ATSG_CONST
  } atsg_form_e;

  // what is currently loaded for playback
  typedef enum logic [2:0] {
    ATSG_SRC_NONE,
    ATSG_SRC_FILE,
    ATSG_SRC_SINE,
    ATSG_SRC_RECT,
    ATSG_SRC_CONST
  } atsg_src_e;

endpackage

// file: verilog/atsg_generator.sv
`timescale 1ns/10ps

// Notes on behaviour
// - sine sample clock equals frequency times samples
// - samples per period clamped to max clock
// - I sine, Q sine shifted by phase offset
// - minus ninety degrees: CCW circle from (0,-1)
// - zero offset gives identical I and Q
// - rectangle half high half low, period 1/f
// - rectangle on I and Q, common shift
// - constant I/Q at fixed 10 kHz clock
// - decimal constants converted to 16-bit words
// - enable refused without waveform, error raised
// - enabled output comes from loaded waveform
// - segment select shown for multi-segment waveform
module atsg_generator
  import atsg_pkg::*;
#(
  parameter int WAVE_DEPTH = 16, // sample pairs held for a file
  parameter int AW         = $clog2(WAVE_DEPTH)
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // test signal settings
  input  wire atsg_form_e        testForm,
  input  wire logic              genStart,
  input  wire logic [31:0]       sineFreqHz,
  input  wire logic [15:0]       samplesPerPeriod,
  input  wire logic [15:0]       phaseOffset,
  input  wire logic [15:0]       rectAmplitude,
  input  wire logic signed [15:0] common_level_shift,
  input  wire logic [20:0]       constIDec,
  input  wire logic [20:0]       constQDec,
  // waveform file loading
  input  wire logic              wrEn,
  input  wire logic [AW-1:0]     wrAddr,
  input  wire logic [15:0]       wrI,
  input  wire logic [15:0]       wrQ,
  input  wire logic              loadFile,
  input  wire logic [31:0]       fileClockHz,
  input  wire logic [7:0]        fileSegCount,
  input  wire logic [15:0]       fileSegLen,
  input  wire logic [7:0]        segSelect,
  // playback control
  input  wire logic              enableOn,
  input  wire logic              enableOff,
  input  wire logic              restoreDefaults,
  // status and sample stream
  output logic                   playback_enable,
  output logic                   noWaveformError,
  output logic                   segmentSelectShown,
  output atsg_src_e              loadedForm,
  output logic [31:0]            sampleClockHz,
  output logic [15:0]            sppEffective,
  output logic                   sampleStrobe,
  output logic signed [15:0]     sampleI,
  output logic signed [15:0]     sampleQ
);

  ////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic                         en;     // playback running
    logic                         err;    // refused-enable flag
    atsg_src_e                    src;    // loaded source
    logic [31:0]                  rate;   // sample clock in Hz
    logic [31:0]                  acc;    // rate accumulator
    logic [15:0]                  period; // samples per period
    logic [15:0]                  idx;    // sample position
    logic [15:0]                  phase;  // sine phase word
    logic [15:0]                  step;   // phase step per sample
    logic [15:0]                  phOff;  // Q phase offset
    logic signed [15:0]           amp;    // rectangle amplitude
    logic signed [15:0]           shift;  // common level shift
    logic signed [15:0]           ci;     // constant I word
    logic signed [15:0]           cq;     // constant Q word
    logic [7:0]                   segCnt; // segments in file
    logic                         strobe; // sample valid
    logic                         first;  // sample was position 0
    logic signed [15:0]           oI;     // I sample out
    logic signed [15:0]           oQ;     // Q sample out
    logic [WAVE_DEPTH-1:0][31:0]  mem;    // file samples {I,Q}
  } atsg_state_s;

  atsg_state_s st;
  atsg_state_s next_st;

  ////////////////////////////////////////////////////////////////////
  // functions

  // quarter sine table, 17 points, Q15
  function automatic logic signed [15:0] quarterSine(input logic [4:0] k);
    logic signed [15:0] v;
    v = POS_FULL;
    unique case (k)
      5'h00: v = 16'sh0000;
      5'h01: v = 16'sh0C8C;
      5'h02: v = 16'sh18F9;
      5'h03: v = 16'sh2528;
      5'h04: v = 16'sh30FB;
      5'h05: v = 16'sh3C56;
      5'h06: v = 16'sh471C;
      5'h07: v = 16'sh5133;
      5'h08: v = 16'sh5A82;
      5'h09: v = 16'sh62F1;
      5'h0A: v = 16'sh6A6D;
      5'h0B: v = 16'sh70E2;
      5'h0C: v = 16'sh7641;
      5'h0D: v = 16'sh7A7C;
      5'h0E: v = 16'sh7D89;
      5'h0F: v = 16'sh7F61;
      default: v = POS_FULL;
    endcase
    return v;
  endfunction

  // full-turn sine from the top six phase bits
  function automatic logic signed [15:0] sine(input logic [15:0] ph);
    logic [4:0]         k;
    logic [4:0]         m;
    logic signed [15:0] a;
    k = {1'b0, ph[13:10]};
    m = 5'h10 - k;
    // mirrored index on odd quadrants, sign on the upper half
    a = ph[14] ? quarterSine(m) : quarterSine(k);
    return ph[15] ? -a : a;
  endfunction

  // clamp a wide sum into one 16-bit sample
  function automatic logic signed [15:0] sat16(input logic signed [17:0] x);
    logic signed [15:0] r;
    r = x[15:0];
    if (x > 18'sh07FFF) begin
      r = POS_FULL;
    end else if (x < -18'sh07FFF) begin
      r = NEG_FULL;
    end
    return r;
  endfunction

  // sign plus five decimal digits to a 16-bit word
  function automatic logic signed [15:0] decToWord(input logic [20:0] d);
    logic [17:0] mag;
    mag = 18'h0;
    for (int i = BCD_DIGITS - 1; i >= 0; i--) begin
      mag = 18'((mag * 18'd10) + 18'(d[i*4 +: 4]));
    end
    // magnitudes beyond full scale saturate rather than wrap
    return sat16(d[20] ? -$signed(mag) : $signed(mag));
  endfunction

  ////////////////////////////////////////////////////////////////////
  // setting decode used by the generator

  logic [31:0] freqNz;    // frequency, zero read as 1 Hz
  logic [31:0] sppLimit;  // largest spp under the clock ceiling
  logic [15:0] sppSine;   // clamped sine samples per period
  logic [15:0] sppRect;   // clamped, even, at least two
  logic [63:0] rateProd;  // frequency times samples
  logic [15:0] sppGen;    // spp of the chosen form
  logic [7:0]  segPick;   // segment actually played
  logic [AW-1:0] rdAddr;  // file read address
  logic [31:0] rdWord;    // file sample pair
  logic [31:0] accSum;    // accumulator plus rate

  always_comb begin
    freqNz   = (sineFreqHz == 32'h0) ? 32'h1 : sineFreqHz;
    sppLimit = MAX_RATE_HZ / freqNz;
    // clamp to the ceiling so the sine product cannot exceed it for frequencies up to the ceiling
    sppSine  = samplesPerPeriod;
    if (32'(samplesPerPeriod) > sppLimit) begin
      sppSine = sppLimit[15:0];
    end
    if (sppSine == 16'h0) begin
      sppSine = 16'h1;
    end
    // rectangle needs an even count for equal halves
    sppRect = {sppSine[15:1], 1'b0};
    if (sppRect == 16'h0) begin
      sppRect = 16'h2;
    end
    sppGen   = (testForm == ATSG_RECT) ? sppRect : sppSine;
    rateProd = 64'(freqNz) * 64'(sppGen);
  end

  // segment choice limited to what the file holds
  always_comb begin
    segPick = (segSelect < st.segCnt) ? segSelect : 8'h0;
    rdAddr  = AW'((32'(segPick) * 32'(st.period)) + 32'(st.idx));
    rdWord  = st.mem[rdAddr];
    accSum  = st.acc + st.rate;
  end

  ////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_st        = st;
    next_st.strobe = 1'b0;
    // sample clock: accumulator overflow past the system rate
    if (st.en) begin
      if (accSum >= CLK_HZ) begin
        next_st.acc    = accSum - CLK_HZ;
        next_st.strobe = 1'b1;
        next_st.first  = (st.idx == 16'h0);
        // samples only ever come from the loaded source
        unique case (st.src)
          ATSG_SRC_SINE: begin
            next_st.oI = sine(st.phase);
            next_st.oQ = sine(st.phase + st.phOff);
          end
          ATSG_SRC_RECT: begin
            // first half high, second half low, both rails alike
            next_st.oI = sat16(18'(st.idx < (st.period >> 1) ? st.amp : -st.amp)
                               + 18'(st.shift));
            next_st.oQ = next_st.oI;
          end
          ATSG_SRC_CONST: begin
            next_st.oI = st.ci;
            next_st.oQ = st.cq;
          end
          ATSG_SRC_FILE: begin
            next_st.oI = rdWord[31:16];
            next_st.oQ = rdWord[15:0];
          end
          default: begin
            next_st.oI = 16'sh0000;
            next_st.oQ = 16'sh0000;
          end
        endcase
        // advance one position; restart phase at wrap to stop drift
        if (st.idx + 16'h1 >= st.period) begin
          next_st.idx   = 16'h0;
          next_st.phase = 16'h0;
        end else begin
          next_st.idx   = st.idx + 16'h1;
          next_st.phase = st.phase + st.step;
        end
      end else begin
        next_st.acc = accSum;
      end
    end
    // file writes go straight into sample storage
    if (wrEn) begin
      next_st.mem[wrAddr] = {wrI, wrQ};
    end
    // file load finished: take its clock and segment layout
    if (loadFile) begin
      next_st.src    = ATSG_SRC_FILE;
      next_st.rate   = (fileClockHz > MAX_RATE_HZ) ? MAX_RATE_HZ : fileClockHz;
      next_st.segCnt = (fileSegCount == 8'h0) ? 8'h1 : fileSegCount;
      next_st.period = (fileSegLen == 16'h0) ? 16'h1 : fileSegLen;
      next_st.err    = 1'b0;
    end
    // test signal creation loads it as the waveform
    if (genStart) begin
      next_st.err    = 1'b0;
      next_st.segCnt = 8'h1;
      next_st.phOff  = phaseOffset;
      next_st.amp    = rectAmplitude;
      next_st.shift  = common_level_shift;
      unique case (testForm)
        ATSG_SINE: begin
          next_st.src    = ATSG_SRC_SINE;
          next_st.rate   = rateProd[31:0];
          next_st.period = sppSine;
          next_st.step   = 16'(PHASE_TURN / 17'(sppSine));
        end
        ATSG_RECT: begin
          next_st.src    = ATSG_SRC_RECT;
          next_st.rate   = rateProd[31:0];
          next_st.period = sppRect;
        end
        ATSG_CONST: begin
          next_st.src    = ATSG_SRC_CONST;
          next_st.rate   = CONST_RATE_HZ;
          next_st.period = 16'h1;
          next_st.ci     = decToWord(constIDec);
          next_st.cq     = decToWord(constQDec);
        end
        default: begin
          next_st.src    = st.src;
        end
      endcase
    end
    // any new load restarts the sequence from position 0
    if (loadFile || genStart) begin
      next_st.idx    = 16'h0;
      next_st.phase  = 16'h0;
      next_st.acc    = 32'h0;
      // a sample computed from the old source is dropped, not shown as new
      next_st.strobe = 1'b0;
      next_st.first  = 1'b0;
    end
    // enable control; defaults beat a same-cycle enable
    if (restoreDefaults) begin
      next_st.en   = 1'b0;
      next_st.err  = 1'b0;
      next_st.rate = DEFAULT_RATE_HZ;
    end else if (enableOff) begin
      next_st.en = 1'b0;
    end else if (enableOn) begin
      if (st.src == ATSG_SRC_NONE) begin
        next_st.err = 1'b1;
      end else begin
        next_st.en  = 1'b1;
        next_st.acc = 32'h0;
      end
    end
    // disabled output is held at zero
    if (!next_st.en) begin
      next_st.strobe = 1'b0;
      next_st.oI     = 16'sh0000;
      next_st.oQ     = 16'sh0000;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st      <= '0;
      st.src  <= ATSG_SRC_NONE;
      st.rate <= DEFAULT_RATE_HZ;
      st.period <= 16'h1;
      st.segCnt <= 8'h1;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign playback_enable    = st.en;
  assign noWaveformError    = st.err;
  assign loadedForm         = st.src;
  assign sampleClockHz      = st.rate;
  assign sppEffective       = st.period;
  assign sampleStrobe       = st.strobe;
  assign sampleI            = st.oI;
  assign sampleQ            = st.oQ;
  assign segmentSelectShown = (st.src == ATSG_SRC_FILE) && (st.segCnt > 8'h1);

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_refusedReq;
    enableOn && !enableOff && !restoreDefaults && (st.src == ATSG_SRC_NONE);
  endsequence
  sequence s_heldOff;
    !playback_enable && noWaveformError;
  endsequence

  property p_refuse;
    s_refusedReq |=> s_heldOff;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("enable accepted with no waveform");

  property p_zeroWhenOff;
    !playback_enable |-> (sampleI == 16'sh0000) && (sampleQ == 16'sh0000) && !sampleStrobe;
  endproperty
  a_zeroWhenOff: assert property (p_zeroWhenOff)
    else $error("nonzero sample while disabled");

  property p_sineRate;
    genStart && (testForm == ATSG_SINE) && !restoreDefaults |=>
      sampleClockHz == 32'(64'($past(freqNz)) * 64'(sppEffective));
  endproperty
  a_sineRate: assert property (p_sineRate)
    else $error("sine sample clock not frequency times samples");

  property p_rateCeiling;
    sampleClockHz <= MAX_RATE_HZ;
  endproperty
  a_rateCeiling: assert property (p_rateCeiling)
    else $error("sample clock above ceiling");

  property p_sineStart;
    sampleStrobe && st.first && (st.src == ATSG_SRC_SINE) && (st.phOff == 16'hC000)
      |-> (sampleI == 16'sh0000) && (sampleQ == NEG_FULL);
  endproperty
  a_sineStart: assert property (p_sineStart)
    else $error("quadrature sine not starting at (0,-1)");

  property p_sineDiag;
    sampleStrobe && (st.src == ATSG_SRC_SINE) && (st.phOff == 16'h0000) |-> sampleI == sampleQ;
  endproperty
  a_sineDiag: assert property (p_sineDiag)
    else $error("zero offset sine differs on I and Q");

  property p_rectSame;
    sampleStrobe && (st.src == ATSG_SRC_RECT) |-> sampleI == sampleQ;
  endproperty
  a_rectSame: assert property (p_rectSame)
    else $error("rectangle differs on I and Q");

  property p_constRate;
    genStart && (testForm == ATSG_CONST) && !loadFile && !restoreDefaults
      |=> sampleClockHz == CONST_RATE_HZ;
  endproperty
  a_constRate: assert property (p_constRate)
    else $error("constant signal not at 10 kHz");

  property p_enableNeedsLoad;
    playback_enable |-> loadedForm != ATSG_SRC_NONE;
  endproperty
  a_enableNeedsLoad: assert property (p_enableNeedsLoad)
    else $error("enabled with nothing loaded");

  property p_advance;
    sampleStrobe && (sppEffective > 16'h1) && playback_enable ##1
      sampleStrobe && playback_enable && !$past(genStart) && !$past(loadFile)
      |-> !(st.first && $past(st.first));
  endproperty
  a_advance: assert property (p_advance)
    else $error("position did not advance");

endmodule

// file: test/atsg_dac_model.sv
`timescale 1ns/10ps

// far-side model: the i/q converter stage takes one word pair per strobe
module atsg_dac_model
  import atsg_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               sampleStrobe,
  input  wire logic signed [15:0] sampleI,
  input  wire logic signed [15:0] sampleQ,
  output logic signed [15:0]      lastI,
  output logic signed [15:0]      lastQ,
  output logic [31:0]             pairCount
);

  ////////////////////////////////////////////////////////////////////////////
  // capture on the strobe only; held words between strobes are not new data
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lastI     <= 16'h0000;
      lastQ     <= 16'h0000;
      pairCount <= 32'h0000_0000;
    end else if (sampleStrobe) begin
      lastI     <= sampleI;
      lastQ     <= sampleQ;
      pairCount <= pairCount + 32'h0000_0001;
    end
  end

endmodule

// file: test/tb_top.sv
`timescale 1ns/10ps

// one compare: counts it, reports a mismatch at once
`define CHK(nm, e, g) begin numChecks++; if ((g) !== (e)) begin errCount++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end

module tb_top;
  import atsg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // stimulus, all given a value at time zero
  logic               clk          = 1'b0;
  logic               sys_rst      = 1'b1;
  atsg_form_e         testForm     = ATSG_SINE;
  logic [4:0]         pulses       = 5'h00; // on, off, defaults, gen, load
  logic [31:0]        sineFreqHz   = 32'h000F_4240;
  logic [15:0]        spp          = 16'h0008;
  logic [15:0]        phaseOffset  = 16'h0000;
  logic [15:0]        rectAmp      = 16'h03E8; // 1000
  logic signed [15:0] levelShift   = 16'sh0064; // 100
  logic [20:0]        constIDec    = 21'h01_2345; // +12345
  logic [20:0]        constQDec    = 21'h10_0100; // -100
  logic               wrEn         = 1'b0;
  logic [3:0]         wrAddr       = 4'h0;
  logic [15:0]        wrI          = 16'h0000;
  logic [15:0]        wrQ          = 16'h0000;
  logic [7:0]         segSelect    = 8'h00;
  // observed
  logic               playback_enable, noWaveformError, segmentSelectShown, sampleStrobe;
  atsg_src_e          loadedForm;
  logic [31:0]        sampleClockHz, pairCount;
  logic [15:0]        sppEffective;
  logic signed [15:0] sampleI, sampleQ, lastI, lastQ;
  int                 errCount     = 0;
  int                 numChecks    = 0;
  int                 cyc          = 0;
  int                 k;
  logic [31:0]        n0;
  // sin(k * 45 deg) at full scale 32767, one entry per sample position
  logic [15:0]        sineRef [8] = '{16'h0000, 16'h5A82, 16'h7FFF, 16'h5A82,
                                      16'h0000, 16'hA57E, 16'h8001, 16'hA57E};

  atsg_generator #(.WAVE_DEPTH(16)) dut (
    .clk(clk), .sys_rst(sys_rst), .testForm(testForm), .genStart(pulses[3]),
    .sineFreqHz(sineFreqHz), .samplesPerPeriod(spp), .phaseOffset(phaseOffset),
    .rectAmplitude(rectAmp), .common_level_shift(levelShift),
    .constIDec(constIDec), .constQDec(constQDec), .wrEn(wrEn), .wrAddr(wrAddr),
    .wrI(wrI), .wrQ(wrQ), .loadFile(pulses[4]), .fileClockHz(32'h0262_5A00),
    .fileSegCount(8'h02), .fileSegLen(16'h0008), .segSelect(segSelect),
    .enableOn(pulses[0]), .enableOff(pulses[1]), .restoreDefaults(pulses[2]),
    .playback_enable(playback_enable), .noWaveformError(noWaveformError),
    .segmentSelectShown(segmentSelectShown), .loadedForm(loadedForm),
    .sampleClockHz(sampleClockHz), .sppEffective(sppEffective),
    .sampleStrobe(sampleStrobe), .sampleI(sampleI), .sampleQ(sampleQ));

  atsg_dac_model dac (
    .clk(clk), .sys_rst(sys_rst), .sampleStrobe(sampleStrobe), .sampleI(sampleI),
    .sampleQ(sampleQ), .lastI(lastI), .lastQ(lastQ), .pairCount(pairCount));

  ////////////////////////////////////////////////////////////////////////////
  // 40 MHz clock
  always #12.5 clk = ~clk;

  // hang guard: the const form alone needs two 4000-cycle sample periods
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      errCount++;
      endOfTest();
    end
  end

  // settle past the edge so registered outputs have landed
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  // one-cycle pulse on a control bit, status read one edge later
  task automatic pulse(input int b);
    @(posedge clk);
    pulses[b] <= 1'b1;
    @(posedge clk);
    pulses    <= 5'h00;
    #1;
  endtask

  // settings and creation of a test signal in one request
  task automatic gen(input atsg_form_e f, input logic [31:0] hz, input logic [15:0] off);
    @(posedge clk);
    testForm    <= f;
    sineFreqHz  <= hz;
    phaseOffset <= off;
    pulses[3]   <= 1'b1;
    @(posedge clk);
    pulses      <= 5'h00;
    #1;
  endtask

  // bounded wait for the next strobe; c returns the cycles taken
  task automatic waitStrobe(output int c);
    c = 0;
    do begin
      tick(1);
      c++;
    end while (sampleStrobe !== 1'b1 && c < 6000);
  endtask

  task automatic endOfTest();
    $display("checks %0d errors %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    tick(1);
    `CHK("enable", 1'b0, playback_enable)
    `CHK("sampleI", 16'h0000, sampleI)
    `CHK("source", ATSG_SRC_NONE, loadedForm)
    // nothing loaded: enable refused
    pulse(0);
    `CHK("error", 1'b1, noWaveformError)
    `CHK("enable", 1'b0, playback_enable)
    // sine, -90 deg: quadrature circle from (0,-1)
    gen(ATSG_SINE, 32'd1000000, 16'hC000);
    `CHK("rate", 32'd8000000, sampleClockHz)
    `CHK("spp", 16'h0008, sppEffective)
    `CHK("errClr", 1'b0, noWaveformError)
    `CHK("segHidden", 1'b0, segmentSelectShown)
    pulse(0);
    `CHK("enable", 1'b1, playback_enable)
    waitStrobe(k);
    `CHK("firstI", 16'h0000, sampleI)
    `CHK("firstQ", NEG_FULL, sampleQ)
    waitStrobe(k);
    `CHK("gap", 5, k)
    `CHK("Ipos", 1'b1, sampleI > 16'sh0000)
    `CHK("quad", -sampleQ, sampleI)
    n0 = pairCount;
    tick(20);
    `CHK("pairs", n0 + 32'd4, pairCount)
    // fast sine: samples per period cut back to fit the playback ceiling
    gen(ATSG_SINE, 32'd10000000, 16'h0000);
    `CHK("ceiling", 1'b1, sampleClockHz <= MAX_RATE_HZ)
    `CHK("product", 32'd40000000, sampleClockHz)
    `CHK("sppCut", 16'h0004, sppEffective)
    // sine, zero offset
    gen(ATSG_SINE, 32'd1000000, 16'h0000);
    pulse(0);
    for (int i = 0; i < 8; i++) begin
      waitStrobe(k);
      `CHK("diag", sampleI, sampleQ)
      `CHK("sineI", sineRef[i], sampleI)
    end
    // rectangle: four high, four low, shifted on both channels
    gen(ATSG_RECT, 32'd1000000, 16'h0000);
    `CHK("rectRate", 32'd8000000, sampleClockHz)
    pulse(0);
    for (int i = 0; i < 8; i++) begin
      waitStrobe(k);
      `CHK("rectI", (i < 4) ? 16'h044C : 16'hFC7C, sampleI)
      `CHK("rectQ", sampleI, sampleQ)
    end
    // constant form at its fixed rate
    gen(ATSG_CONST, 32'd1000000, 16'h0000);
    `CHK("constRate", CONST_RATE_HZ, sampleClockHz)
    pulse(0);
    waitStrobe(k);
    `CHK("constI", 16'h3039, sampleI)
    `CHK("constQ", 16'hFF9C, sampleQ)
    waitStrobe(k);
    `CHK("constGap", 4000, k)
    // file of two segments, segment 1 played
    pulse(1);
    for (int a = 0; a < 16; a++) begin
      @(posedge clk);
      wrEn   <= 1'b1;
      wrAddr <= a[3:0];
      wrI    <= 16'h1000 + a[15:0];
      wrQ    <= 16'h2000 + a[15:0];
    end
    @(posedge clk);
    wrEn      <= 1'b0;
    segSelect <= 8'h01;
    pulses[4] <= 1'b1;
    @(posedge clk);
    pulses    <= 5'h00;
    #1;
    `CHK("segShown", 1'b1, segmentSelectShown)
    `CHK("source", ATSG_SRC_FILE, loadedForm)
    pulse(0);
    waitStrobe(k);
    for (int i = 0; i < 4; i++) begin
      `CHK("fileI", 16'h1008 + i[15:0], sampleI)
      `CHK("fileQ", 16'h2008 + i[15:0], sampleQ)
      tick(1);
    end
    // defaults: stop, zero words, 1 MHz, source kept
    pulse(2);
    `CHK("enable", 1'b0, playback_enable)
    `CHK("rate", DEFAULT_RATE_HZ, sampleClockHz)
    `CHK("sampleQ", 16'h0000, sampleQ)
    `CHK("dacI", 16'h100D, lastI)
    `CHK("dacQ", 16'h200D, lastQ)
    tick(3);
    `CHK("strobe", 1'b0, sampleStrobe)
    `CHK("dacHold", 16'h100D, lastI)
    endOfTest();
  end

endmodule
